// ==== rtl/usb_chan_pkg.sv ====
// Shared constants and carrier types for the host channel setup and status block.
// Assumes an 8-bit register port with 9-bit byte addresses and a host serial engine outside.
package usb_chan_pkg;

  // Register offsets.
  localparam logic [8:0] ofs_chb_kind       = 9'h1a1;
  localparam logic [8:0] ofs_chb_target     = 9'h1a9;
  localparam logic [8:0] ofs_chb_period_hi  = 9'h1aa;
  localparam logic [8:0] ofs_chb_period_lo  = 9'h1ab;
  localparam logic [8:0] ofs_chb_result     = 9'h1ae;
  localparam logic [8:0] ofs_chc_setup_zero = 9'h1b0;
  localparam logic [8:0] ofs_chc_flags      = 9'h1b8;

  // Field positions and widths.
  localparam int func_lsb      = 4;
  localparam int ep_lsb        = 0;
  localparam int kind_lsb      = 4;
  localparam int result_lsb    = 4;
  localparam int ack_thr_lsb   = 4;
  localparam int speed_lsb     = 2;
  localparam int toggle_bit    = 1;
  localparam int launch_bit    = 0;
  localparam int ack_flag_bit  = 0;
  localparam int period_mf_w   = 3;

  // Reset values.
  localparam logic [7:0]  chb_target_reset  = 8'h00;
  localparam logic [10:0] chb_period_reset  = 11'h000;
  localparam logic [1:0]  chb_kind_reset    = 2'h0;
  localparam logic [2:0]  chb_result_reset  = 3'h0;
  localparam logic [7:0]  chc_setup_reset   = 8'h10;

  // Result codes.
  localparam logic [2:0] result_ok            = 3'h0;
  localparam logic [2:0] result_stalled       = 3'h1;
  localparam logic [2:0] result_too_much_data = 3'h2;
  localparam logic [2:0] result_short_data    = 3'h3;
  localparam logic [2:0] result_retry_fail    = 3'h4;

  localparam logic [1:0] kind_interrupt = 2'h3;
  localparam logic [1:0] speed_high     = 2'h0;
  localparam logic [1:0] speed_full     = 2'h1;
  localparam logic [1:0] speed_low      = 2'h3;
  localparam logic [1:0] nyet_limit     = 2'h3;
  localparam logic [4:0] ack_thr_zero   = 5'h10;

  // Timing.
  localparam int microframe_ns     = 125000;
  localparam int clk_period_ns     = 20;
  localparam int microframe_cycles = microframe_ns / clk_period_ns;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_req_t;

  typedef struct packed {
    logic [3:0] target_function_addr;
    logic [3:0] target_endpoint_num;
  } chb_target_t;

  typedef struct packed {
    logic stall;
    logic oversize;
    logic over_total;
    logic short_pkt;
    logic timeout;
    logic crc_err;
    logic stuff_err;
    logic pid_check_err;
    logic pid_undef;
    logic toggle_err;
    logic split_err;
    logic split_nyet;
  } chb_outcome_t;

  typedef struct packed {
    logic ack;
    logic toggle_upd;
    logic toggle;
    logic done;
  } chc_engine_t;

endpackage

// ==== rtl/poll_timer.sv ====
// Polling period timer counting whole microframes of the core clock.
// Assumes restart is a one-cycle pulse from the owner at each token grant.
`timescale 1ns/10ps
module poll_timer #(
  parameter int mf_cycles = usb_chan_pkg::microframe_cycles
) (
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  // Control
  input  wire logic        restart_in,
  input  wire logic [10:0] period_mf_in,
  // Status
  output logic             expired_out
);

  typedef struct packed {
    logic [12:0] tick;
    logic [10:0] left;
    logic        expired;
  } timer_st_t;

  localparam logic [12:0] tick_last = 13'(mf_cycles - 1);

  timer_st_t s_reg;
  timer_st_t s_next;

  always_comb begin
    s_next = s_reg;
    if (restart_in) begin
      s_next.tick    = 13'h0000;
      s_next.left    = period_mf_in;
      s_next.expired = (period_mf_in == 11'h000);
    end else if (!s_reg.expired) begin
      if (s_reg.tick == tick_last) begin
        s_next.tick = 13'h0000;
        if (s_reg.left <= 11'h001) begin
          s_next.left    = 11'h000;
          s_next.expired = 1'b1;
        end else begin
          s_next.left = s_reg.left - 11'h001;
        end
      end else begin
        s_next.tick = s_reg.tick + 13'h0001;
      end
    end
  end

  // Expired after reset so that the first token is not held back.
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s_reg <= '{tick: 13'h0000, left: 11'h000, expired: 1'b1};
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign expired_out = s_reg.expired;

  restart_load_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    ce_in && restart_in && period_mf_in != 11'h000 |=> !expired_out)
    else $error("Timer did not start on restart.");

endmodule // poll_timer

// ==== rtl/usb_host_channel_setup_status.sv ====
// Host channel setup and status: channel two targeting, polling and result code,
// channel three first setup register with ACK counting, launch and toggle.
// Assumes a host serial engine that requests token slots and reports outcomes as pulses.
`timescale 1ns/10ps
module usb_host_channel_setup_status #(
  parameter int mf_cycles = usb_chan_pkg::microframe_cycles
) (
  // Clock, reset, enable
  input  wire logic                       mclk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       ce_in,
  // Register port
  input  wire usb_chan_pkg::reg_bus_req_t bus_in,
  output logic [7:0]                      rdata_out,
  // Channel two engine side
  input  wire logic                       chb_req_in,
  output logic                            chb_grant_out,
  output usb_chan_pkg::chb_target_t       chb_target_out,
  input  wire logic                       chb_done_in,
  input  wire usb_chan_pkg::chb_outcome_t chb_outcome_in,
  // Channel three engine side
  input  wire usb_chan_pkg::chc_engine_t  chc_eng_in,
  output logic                            chc_run_out,
  output logic                            chc_toggle_out,
  output logic [1:0]                      chc_speed_out,
  output logic                            chc_ack_reached_out
);

  typedef struct packed {
    logic [7:0]  rdata;
    logic [7:0]  target;
    logic [10:0] period;
    logic [1:0]  kind;
    logic [2:0]  result;
    logic [1:0]  nyet_cnt;
    logic [3:0]  ack_thr;
    logic [1:0]  speed;
    logic        toggle;
    logic        run;
    logic [4:0]  ack_cnt;
    logic        ack_flag;
    logic        grant;
  } st_t;

  st_t         s_reg;
  st_t         s_next;
  logic        slot_open;
  logic [10:0] period_mf;
  logic        wr_setup;
  logic [4:0]  ack_goal;
  logic [4:0]  ack_cnt_inc;
  logic [2:0]  outcome_code;
  logic        outcome_posts;

  // Microframe field takes precedence if software breaks the one-field-only setting.
  always_comb begin
    if (s_reg.period[2:0] != 3'h0) begin
      period_mf = {8'h00, s_reg.period[2:0]};
    end else begin
      period_mf = {s_reg.period[10:3], 3'h0};
    end
  end

  poll_timer #(
    .mf_cycles (mf_cycles)
  ) u_poll_timer (
    .mclk_in      (mclk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .restart_in   (s_next.grant),
    .period_mf_in (period_mf),
    .expired_out  (slot_open)
  );

  // Outcome classification; CRC and stuff errors override size faults.
  always_comb begin
    outcome_code  = usb_chan_pkg::result_ok;
    outcome_posts = 1'b1;
    if (chb_outcome_in.crc_err || chb_outcome_in.stuff_err) begin
      outcome_code = usb_chan_pkg::result_retry_fail;
    end else if (chb_outcome_in.stall) begin
      outcome_code = usb_chan_pkg::result_stalled;
    end else if (chb_outcome_in.oversize
                 || (chb_outcome_in.over_total && !chb_outcome_in.toggle_err)) begin
      // A packet within size with a bad toggle is a toggle mismatch, not an overrun.
      outcome_code = usb_chan_pkg::result_too_much_data;
    end else if (chb_outcome_in.timeout || chb_outcome_in.pid_check_err
                 || chb_outcome_in.pid_undef || chb_outcome_in.toggle_err
                 || chb_outcome_in.split_err) begin
      outcome_code = usb_chan_pkg::result_retry_fail;
    end else if (chb_outcome_in.split_nyet) begin
      outcome_code  = usb_chan_pkg::result_retry_fail;
      outcome_posts = (s_reg.nyet_cnt + 2'h1 == usb_chan_pkg::nyet_limit);
    end else if (chb_outcome_in.short_pkt) begin
      outcome_code = usb_chan_pkg::result_short_data;
    end
  end

  assign wr_setup    = bus_in.wr && bus_in.addr == usb_chan_pkg::ofs_chc_setup_zero;
  assign ack_goal    = (s_reg.ack_thr == 4'h0) ? usb_chan_pkg::ack_thr_zero
                                                : {1'b0, s_reg.ack_thr};
  assign ack_cnt_inc = s_reg.ack_cnt + 5'h01;

  always_comb begin
    s_next       = s_reg;
    s_next.rdata = 8'h00;
    s_next.grant = 1'b0;

    // Register reads; unmapped addresses and reserved bits read zero.
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        usb_chan_pkg::ofs_chb_kind:       s_next.rdata = {2'h0, s_reg.kind, 4'h0};
        usb_chan_pkg::ofs_chb_target:     s_next.rdata = s_reg.target;
        usb_chan_pkg::ofs_chb_period_hi:  s_next.rdata = {5'h00, s_reg.period[10:8]};
        usb_chan_pkg::ofs_chb_period_lo:  s_next.rdata = s_reg.period[7:0];
        usb_chan_pkg::ofs_chb_result:     s_next.rdata = {1'b0, s_reg.result, 4'h0};
        usb_chan_pkg::ofs_chc_setup_zero: s_next.rdata = {s_reg.ack_thr, s_reg.speed,
                                                          s_reg.toggle, s_reg.run};
        usb_chan_pkg::ofs_chc_flags:      s_next.rdata = {7'h00, s_reg.ack_flag};
        default:                          s_next.rdata = 8'h00;
      endcase
    end

    // Register writes; the result register is read only.
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        usb_chan_pkg::ofs_chb_kind:      s_next.kind = bus_in.wdata[5:4];
        usb_chan_pkg::ofs_chb_target:    s_next.target = bus_in.wdata;
        usb_chan_pkg::ofs_chb_period_hi: s_next.period[10:8] = bus_in.wdata[2:0];
        usb_chan_pkg::ofs_chb_period_lo: s_next.period[7:0] = bus_in.wdata;
        default: ;
      endcase
    end

    // Token slot gate; retries come through the same request and wait alike.
    if (chb_req_in && !s_reg.grant) begin
      if (s_reg.kind != usb_chan_pkg::kind_interrupt || period_mf == 11'h000) begin
        s_next.grant = 1'b1;
      end else if (slot_open) begin
        s_next.grant = 1'b1;
      end
    end

    // Result code posting and the consecutive NYET count.
    if (chb_done_in) begin
      if (chb_outcome_in.split_nyet && !outcome_posts) begin
        s_next.nyet_cnt = s_reg.nyet_cnt + 2'h1;
      end else begin
        s_next.nyet_cnt = 2'h0;
        s_next.result   = outcome_code;
      end
    end

    // Channel three: engine ends the run, toggle follows the engine.
    if (chc_eng_in.done) begin
      s_next.run = 1'b0;
    end
    if (chc_eng_in.toggle_upd) begin
      s_next.toggle = chc_eng_in.toggle;
    end
    if (chc_eng_in.ack && s_reg.run) begin
      if (ack_cnt_inc == ack_goal) begin
        s_next.ack_flag = 1'b1;
        s_next.ack_cnt  = 5'h00;
      end else begin
        s_next.ack_cnt = ack_cnt_inc;
      end
    end

    // Software clears the ACK flag by writing one; a same-cycle set wins.
    if (bus_in.wr && bus_in.addr == usb_chan_pkg::ofs_chc_flags
        && bus_in.wdata[usb_chan_pkg::ack_flag_bit] && !s_next.ack_flag) begin
      s_next.ack_flag = 1'b0;
    end else if (bus_in.wr && bus_in.addr == usb_chan_pkg::ofs_chc_flags
                 && bus_in.wdata[usb_chan_pkg::ack_flag_bit]
                 && !(chc_eng_in.ack && s_reg.run && ack_cnt_inc == ack_goal)) begin
      s_next.ack_flag = 1'b0;
    end

    // Setup writes; a launch written with a completion in the same cycle still starts.
    if (wr_setup) begin
      s_next.ack_thr = bus_in.wdata[7:4];
      s_next.speed   = bus_in.wdata[3:2];
      if (!s_reg.run) begin
        s_next.toggle = bus_in.wdata[usb_chan_pkg::toggle_bit];
      end
      if (bus_in.wdata[usb_chan_pkg::launch_bit]) begin
        s_next.run = 1'b1;
        if (!s_reg.run) begin
          s_next.ack_cnt = 5'h00;
        end
      end else begin
        s_next.run = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      s_reg <= '{rdata:    8'h00,
                 target:   usb_chan_pkg::chb_target_reset,
                 period:   usb_chan_pkg::chb_period_reset,
                 kind:     usb_chan_pkg::chb_kind_reset,
                 result:   usb_chan_pkg::chb_result_reset,
                 nyet_cnt: 2'h0,
                 ack_thr:  usb_chan_pkg::chc_setup_reset[7:4],
                 speed:    usb_chan_pkg::chc_setup_reset[3:2],
                 toggle:   usb_chan_pkg::chc_setup_reset[1],
                 run:      usb_chan_pkg::chc_setup_reset[0],
                 ack_cnt:  5'h00,
                 ack_flag: 1'b0,
                 grant:    1'b0};
    end else if (ce_in) begin
      s_reg <= s_next;
    end
  end

  assign rdata_out           = s_reg.rdata;
  assign chb_grant_out       = s_reg.grant;
  assign chb_target_out      = s_reg.target;
  assign chc_run_out         = s_reg.run;
  assign chc_toggle_out      = s_reg.toggle;
  assign chc_speed_out       = s_reg.speed;
  assign chc_ack_reached_out = s_reg.ack_flag;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  function automatic logic any_retry(usb_chan_pkg::chb_outcome_t o);
    return o.timeout | o.pid_check_err | o.pid_undef | o.toggle_err | o.split_err;
  endfunction

  target_drive_a: assert property (ce_in && bus_in.wr
    && bus_in.addr == usb_chan_pkg::ofs_chb_target
    |=> chb_target_out.target_function_addr == $past(bus_in.wdata[7:4])
        && chb_target_out.target_endpoint_num == $past(bus_in.wdata[3:0]))
    else $error("Target address not taken from write.");

  result_read_a: assert property (ce_in && bus_in.rd
    && bus_in.addr == usb_chan_pkg::ofs_chb_result
    |=> rdata_out == {1'b0, $past(s_reg.result), 4'h0})
    else $error("Result read has wrong layout.");

  stall_code_a: assert property (ce_in && chb_done_in && chb_outcome_in.stall
    && !chb_outcome_in.crc_err && !chb_outcome_in.stuff_err
    |=> s_reg.result == usb_chan_pkg::result_stalled)
    else $error("Stall not reported as 001.");

  overrun_code_a: assert property (ce_in && chb_done_in && chb_outcome_in.oversize
    && !chb_outcome_in.stall && !chb_outcome_in.crc_err && !chb_outcome_in.stuff_err
    |=> s_reg.result == usb_chan_pkg::result_too_much_data)
    else $error("Overrun not reported as 010.");

  crc_beats_size_a: assert property (ce_in && chb_done_in && chb_outcome_in.crc_err
    && (chb_outcome_in.oversize || chb_outcome_in.short_pkt)
    |=> s_reg.result == usb_chan_pkg::result_retry_fail)
    else $error("CRC with size fault not a retry error.");

  toggle_in_size_a: assert property (ce_in && chb_done_in
    && chb_outcome_in.over_total && chb_outcome_in.toggle_err
    && !chb_outcome_in.oversize && !chb_outcome_in.stall
    |=> s_reg.result == usb_chan_pkg::result_retry_fail)
    else $error("Toggle mismatch within size reported as overrun.");

  short_code_a: assert property (ce_in && chb_done_in && chb_outcome_in.short_pkt
    && !chb_outcome_in.stall && !chb_outcome_in.oversize && !chb_outcome_in.over_total
    && !chb_outcome_in.crc_err && !chb_outcome_in.stuff_err && !chb_outcome_in.split_nyet
    && !any_retry(chb_outcome_in)
    |=> s_reg.result == usb_chan_pkg::result_short_data)
    else $error("Short packet not reported as 011.");

  retry_code_a: assert property (ce_in && chb_done_in && any_retry(chb_outcome_in)
    && !chb_outcome_in.stall && !chb_outcome_in.oversize && !chb_outcome_in.over_total
    |=> s_reg.result == usb_chan_pkg::result_retry_fail)
    else $error("Retry condition not reported as 100.");

  ack_reach_a: assert property (ce_in && s_reg.run && chc_eng_in.ack
    && ack_cnt_inc == ack_goal |=> chc_ack_reached_out)
    else $error("ACK flag missed at threshold.");

  flag_clear_a: assert property (ce_in && bus_in.wr
    && bus_in.addr == usb_chan_pkg::ofs_chc_flags && bus_in.wdata[usb_chan_pkg::ack_flag_bit]
    && !(chc_eng_in.ack && s_reg.run && ack_cnt_inc == ack_goal) |=> !chc_ack_reached_out)
    else $error("ACK flag not cleared by write of one.");

  launch_run_a: assert property (ce_in && wr_setup && bus_in.wdata[0]
    |=> chc_run_out ##1 (chc_run_out || $past(chc_eng_in.done) || $past(wr_setup)
        || !$past(ce_in)))
    else $error("Launch bit did not start or dropped early.");

  poll_gate_a: assert property (ce_in && chb_req_in && !chb_grant_out
    && s_reg.kind != usb_chan_pkg::kind_interrupt |=> chb_grant_out)
    else $error("Non-interrupt request not granted at once.");

  poll_wait_a: assert property (ce_in && chb_req_in && !chb_grant_out && slot_open
    && s_reg.kind == usb_chan_pkg::kind_interrupt && period_mf != 11'h000
    |=> chb_grant_out && !slot_open)
    else $error("Polling timer not restarted by grant.");

  held_back_a: assert property (ce_in && chb_req_in && !slot_open
    && period_mf != 11'h000
    && s_reg.kind == usb_chan_pkg::kind_interrupt |=> !chb_grant_out)
    else $error("Token granted inside polling period.");

  interrupt_poll_c: cover property (ce_in && chb_req_in && slot_open
    && s_reg.kind == usb_chan_pkg::kind_interrupt && period_mf != 11'h000);
  nyet_retry_c: cover property (ce_in && chb_done_in && chb_outcome_in.split_nyet
    && outcome_posts);
  ack_reach_c: cover property (chc_ack_reached_out);
  launch_done_c: cover property (chc_run_out ##1 !chc_run_out);

endmodule // usb_host_channel_setup_status

// ==== testbench/usb_far_end_model.sv ====
// Far-end model: host serial engine plus the USB device behind channels two and three.
// Assumes the bench orders tokens, outcomes and engine events by one-cycle pulses.
`timescale 1ns/10ps
module usb_far_end_model (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_b_in,
  // Bench orders
  input  wire logic                       ask_in,
  input  wire logic                       post_in,
  input  wire usb_chan_pkg::chb_outcome_t outcome_in,
  input  wire usb_chan_pkg::chc_engine_t  chc_cmd_in,
  // Block side
  input  wire logic                       chb_grant_in,
  output logic                            chb_req_out,
  output logic                            chb_done_out,
  output usb_chan_pkg::chb_outcome_t      chb_outcome_out,
  output usb_chan_pkg::chc_engine_t       chc_eng_out
);
  // Outcome lines mean nothing outside a done pulse, so they flip every cycle there.
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      chb_req_out     <= 1'b0;
      chb_done_out    <= 1'b0;
      chb_outcome_out <= '0;
      chc_eng_out     <= '0;
    end else begin
      chb_req_out     <= ask_in | (chb_req_out & ~chb_grant_in);
      chb_done_out    <= post_in;
      chb_outcome_out <= post_in ? outcome_in : ~chb_outcome_out;
      chc_eng_out     <= chc_cmd_in;
    end
  end
endmodule // usb_far_end_model

// ==== testbench/usb_host_channel_setup_status_tb_top.sv ====
// Self-checking bench for the host channel setup and status block.
// Assumes the far-end model file is compiled first and a short microframe count.
`timescale 1ns/10ps
module usb_host_channel_setup_status_tb_top;
  localparam int mf_cycles_sim = 4;
  logic                       mclk_in = 1'b0;
  logic                       rst_b_in = 1'b0;
  usb_chan_pkg::reg_bus_req_t bus = '0;
  logic [7:0]                 rdata_out;
  logic                       chb_req, chb_grant_out, chb_done;
  usb_chan_pkg::chb_target_t  chb_target_out;
  usb_chan_pkg::chb_outcome_t chb_outcome;
  usb_chan_pkg::chb_outcome_t outcome_cmd = '0;
  usb_chan_pkg::chc_engine_t  chc_eng;
  usb_chan_pkg::chc_engine_t  chc_cmd = '0;
  logic                       chc_run_out, chc_toggle_out, chc_ack_reached_out;
  logic [1:0]                 chc_speed_out;
  logic                       ask = 1'b0;
  logic                       ce = 1'b1;
  logic                       post_cmd = 1'b0;
  int                         fails = 0;
  int                         tests_run = 0;
  int                         since = 0;
  int                         cycles = 0;

  usb_host_channel_setup_status #(.mf_cycles(mf_cycles_sim)) i_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce), .bus_in(bus), .rdata_out(rdata_out),
    .chb_req_in(chb_req), .chb_grant_out(chb_grant_out), .chb_target_out(chb_target_out),
    .chb_done_in(chb_done), .chb_outcome_in(chb_outcome), .chc_eng_in(chc_eng),
    .chc_run_out(chc_run_out), .chc_toggle_out(chc_toggle_out), .chc_speed_out(chc_speed_out),
    .chc_ack_reached_out(chc_ack_reached_out));

  usb_far_end_model i_far (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .ask_in(ask), .post_in(post_cmd),
    .outcome_in(outcome_cmd), .chc_cmd_in(chc_cmd), .chb_grant_in(chb_grant_out),
    .chb_req_out(chb_req), .chb_done_out(chb_done), .chb_outcome_out(chb_outcome),
    .chc_eng_out(chc_eng));

  initial begin
    forever #10 mclk_in = ~mclk_in;
  end

  // Since holds the cycles between the last two grants when a grant is seen.
  always @(posedge mclk_in) begin
    since <= chb_grant_out ? 1 : since + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_gap(input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value grant gap expected %0d to %0d seen %0d", lo, hi, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [8:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    @(negedge mclk_in);
    chk(what, exp, rdata_out);
  endtask

  task automatic post(input logic [11:0] o);
    @(posedge mclk_in);
    post_cmd <= 1'b1;
    outcome_cmd <= usb_chan_pkg::chb_outcome_t'(o);
    @(posedge mclk_in);
    post_cmd <= 1'b0;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic eng(input logic [3:0] c);
    @(posedge mclk_in);
    chc_cmd <= usb_chan_pkg::chc_engine_t'(c);
    @(posedge mclk_in);
    chc_cmd <= '0;
    @(posedge mclk_in);
    @(negedge mclk_in);
  endtask

  task automatic token(output int g);
    int n;
    n = 0;
    @(posedge mclk_in);
    ask <= 1'b1;
    @(posedge mclk_in);
    ask <= 1'b0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (chb_grant_out !== 1'b1 && n < 9000);
    g = since;
  endtask

  task automatic t_reset;
    rdchk("period_hi", 9'h1aa, 8'h00);
    rdchk("period_lo", 9'h1ab, 8'h00);
    rdchk("result", 9'h1ae, 8'h00);
    rdchk("setup", 9'h1b0, 8'h10);
    rdchk("unmapped", 9'h1ff, 8'h00);
  endtask

  task automatic t_regs;
    logic [7:0] v [3] = '{8'hf0, 8'h0f, 8'ha5};
    foreach (v[i]) begin
      wr(9'h1a9, v[i]);
      rdchk("target", 9'h1a9, v[i]);
      chk("target_out", v[i], chb_target_out);
    end
    // A write made while the clock enable is low must leave the register as it was.
    @(posedge mclk_in);
    ce <= 1'b0;
    wr(9'h1a9, 8'h5a);
    ce <= 1'b1;
    rdchk("target_frozen", 9'h1a9, 8'ha5);
    wr(9'h1aa, 8'hff);
    rdchk("period_hi", 9'h1aa, 8'h07);
    wr(9'h1ae, 8'hff);
    rdchk("result", 9'h1ae, 8'h00);
  endtask

  // Each period is primed by one grant, then the next grant's distance is measured.
  task automatic t_poll;
    int g;
    logic [7:0] hi [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
    logic [7:0] lo [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'hf8};
    int mfs [6] = '{0, 1, 2, 4, 8, 2040};
    wr(9'h1a1, 8'h30);
    foreach (mfs[i]) begin
      wr(9'h1aa, hi[i]);
      wr(9'h1ab, lo[i]);
      token(g);
      token(g);
      chk_gap(mfs[i] * mf_cycles_sim, mfs[i] * mf_cycles_sim + 4, g);
    end
    wr(9'h1a1, 8'h20);
    token(g);
    token(g);
    chk_gap(0, 4, g);
  endtask

  task automatic t_result;
    logic [11:0] o [16] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020,
                            12'h010, 12'h008, 12'h004, 12'h002, 12'h440, 12'h220, 12'h140,
                            12'h204, 12'h000};
    logic [2:0] c [16] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4,
                           3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0};
    foreach (o[i]) begin
      post(o[i]);
      rdchk("result", 9'h1ae, {1'b0, c[i], 4'h0});
    end
    repeat (2) begin
      post(12'h001);
      rdchk("result", 9'h1ae, 8'h00);
    end
    post(12'h001);
    rdchk("result", 9'h1ae, 8'h40);
  endtask

  task automatic t_chc;
    logic [1:0] s [3] = '{2'h0, 2'h1, 2'h3};
    wr(9'h1b0, 8'h21);
    @(negedge mclk_in);
    chk("run", 8'h01, {7'h0, chc_run_out});
    eng(4'h8);
    chk("ack_flag", 8'h00, {7'h0, chc_ack_reached_out});
    eng(4'h8);
    chk("ack_flag", 8'h01, {7'h0, chc_ack_reached_out});
    eng(4'h1);
    rdchk("setup", 9'h1b0, 8'h20);
    wr(9'h1b8, 8'h01);
    rdchk("flags", 9'h1b8, 8'h00);
    wr(9'h1b0, 8'h01);
    repeat (15) eng(4'h8);
    chk("ack_flag", 8'h00, {7'h0, chc_ack_reached_out});
    eng(4'h8);
    chk("ack_flag", 8'h01, {7'h0, chc_ack_reached_out});
    wr(9'h1b0, 8'h00);
    rdchk("setup", 9'h1b0, 8'h00);
    foreach (s[i]) begin
      wr(9'h1b0, {4'h1, s[i], 2'b00});
      @(negedge mclk_in);
      chk("speed", {6'h0, s[i]}, {6'h0, chc_speed_out});
    end
    wr(9'h1b0, 8'h12);
    @(negedge mclk_in);
    chk("toggle", 8'h01, {7'h0, chc_toggle_out});
    wr(9'h1b0, 8'h13);
    eng(4'h4);
    rdchk("setup", 9'h1b0, 8'h11);
    wr(9'h1b0, 8'h13);
    rdchk("setup", 9'h1b0, 8'h11);
  endtask

  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    t_reset;
    t_regs;
    t_poll;
    t_result;
    t_chc;
    print_verdict;
  end
endmodule // usb_host_channel_setup_status_tb_top
